// ==== src/vhm_top.sv ====
// voltage hold logic with AHB-Lite register slave
// Summary of operation
// [R1] arm only after 2.5 s healthy voltage
// [R2] all used voltages below entry threshold
// [R3] optional: one phase current above limit
// [R4] hold shows threshold as voltage amplitude
// [R5] pre-fault angles frozen during hold
// [R6] hold active output while holding
// [R7] block input sampled at cycle start
// [R8] angles 0 to 360.00 deg, 0.01 step
// [R9] inputs three, four valid only sync mode
// [R10] fundamental and harmonics 2..31 selectable
// [R11] harmonics as percent or absolute
// [R12] report largest harmonic of selected input
// [R13] amplitude and power THD, 0.001 resolution
// [R14] time limit ends hold, blocks, clears trips
// [R15] threshold in percent, default 15.00
// [R16] release on recovery or disable
`timescale 1ns/10ps
`default_nettype none
module vhm_top
  import vhm_pkg::*;
#(
  parameter int CYCLE_LEN = CYCLE_CLKS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // measurement front end
  input wire vhm_meas_t meas,
  input wire vhm_harm_t harm_in,
  input wire logic hold_block_in,
  // to directional stages
  output logic hold_active,
  output logic [15:0] ref_amplitude,
  output logic [NUM_V-1:0][15:0] ref_angle,
  output logic [NUM_V-1:0] ref_angle_valid,
  output logic dependent_block,
  output logic clear_start_trip
);
  initial begin
    if (CYCLE_LEN < 1) $error("vhm_top: cycle length too small");
  end
  // settings and state
  logic [3:0] ctrl, next_ctrl;
  logic [15:0] thr, next_thr;        // entry threshold [R15]
  logic [15:0] cur_lim, next_cur_lim;
  logic [15:0] limit, next_limit;    // hold time, 5 ms units
  logic [1:0] hsel_in, next_hsel_in;
  logic [4:0] hsel_ord, next_hsel_ord;
  // bus data phase
  logic ph_wr, next_ph_wr, ph_rd, next_ph_rd;
  logic [7:0] ph_adr, next_ph_adr;
  logic [31:0] rdata_mux;
  // program cycle divider
  logic [31:0] div, next_div;
  logic tick;
  // hold machine
  vhm_state_t st, next_st;
  logic [15:0] healthy_cnt, next_healthy_cnt;
  logic [15:0] hold_cnt, next_hold_cnt;
  logic blk, next_blk;
  logic expired, next_expired;
  logic [NUM_V-1:0][15:0] ang, next_ang;
  logic all_low, all_healthy, cur_ok, v34_ok;
  logic [23:0] harm_value, max_harmonic_value, thd_amp, thd_pow;
  logic [NUM_V-1:0] used_eff;

  // bus address phase capture
  always_comb begin
    next_ph_wr = 1'b0;
    next_ph_rd = 1'b0;
    next_ph_adr = ph_adr;
    if (hsel && hready && htrans[1]) begin
      next_ph_wr = hwrite;
      next_ph_rd = !hwrite;
      next_ph_adr = haddr[7:0];
    end
  end
  // register writes in data phase; unmapped writes are dropped
  always_comb begin
    next_ctrl = ctrl;
    next_thr = thr;
    next_cur_lim = cur_lim;
    next_limit = limit;
    next_hsel_in = hsel_in;
    next_hsel_ord = hsel_ord;
    if (ph_wr) begin
      case (ph_adr)
        OFS_CTRL: next_ctrl = hwdata[3:0];
        OFS_THR: next_thr = hwdata[15:0]; // [R15]
        OFS_CUR: next_cur_lim = hwdata[15:0];
        // clamp to the longest allowed hold time [R14]
        OFS_LIMIT: next_limit = (32'(hwdata[15:0]) * LIMIT_STEP_MS
                   > LIMIT_MAX_MS) ? 16'(LIMIT_MAX_MS / LIMIT_STEP_MS)
                   : hwdata[15:0];
        OFS_HSEL: begin
          next_hsel_in = hwdata[1:0];
          next_hsel_ord = hwdata[12:8]; // [R10]
        end
        default: ;
      endcase
    end
  end
  // read mux; narrow fields sit low except the order field at bits 12:8, others zero
  always_comb begin
    rdata_mux = '0;
    case (ph_adr)
      OFS_CTRL: rdata_mux = {28'h0, ctrl};
      OFS_THR: rdata_mux = {16'h0, thr};
      OFS_CUR: rdata_mux = {16'h0, cur_lim};
      OFS_LIMIT: rdata_mux = {16'h0, limit};
      OFS_STAT: rdata_mux = {27'h0, v34_ok, blk, expired,
                             st == VHM_ARMED, st == VHM_HOLD};
      OFS_HSEL: rdata_mux = {19'h0, hsel_ord, 6'h0, hsel_in};
      OFS_HARM: rdata_mux = {8'h0, harm_value};
      OFS_MAXH: rdata_mux = {8'h0, max_harmonic_value}; // [R12]
      OFS_THDA: rdata_mux = {8'h0, thd_amp};
      OFS_THDP: rdata_mux = {8'h0, thd_pow};
      default: begin
        // three-bit compare: a count of four does not fit two bits
        if (ph_adr[7:4] == OFS_ANG0[7:4] && 3'(ph_adr[3:2]) < 3'(NUM_V))
          rdata_mux = {16'h0, ref_angle[ph_adr[3:2]]}; // [R8]
      end
    endcase
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = ph_rd ? rdata_mux : '0;

  // program cycle divider: one pulse per cycle
  always_comb begin
    next_div = (div >= 32'(CYCLE_LEN - 1)) ? '0 : div + 32'h1;
    tick = (div == '0);
  end

  // qualifiers on live measurements
  always_comb begin
    v34_ok = ctrl[CTRL_SYNC] && meas.vused[2] && meas.vused[3]; // [R9]
    used_eff = meas.vused & (v34_ok ? 4'hF : 4'h3);
    all_low = (used_eff != '0);
    all_healthy = (used_eff != '0);
    for (int i = 0; i < NUM_V; i++) begin
      if (used_eff[i] && meas.vmag[i] >= thr) all_low = 1'b0; // [R2]
      if (used_eff[i] && meas.vmag[i] < thr) all_healthy = 1'b0;
    end
    cur_ok = !ctrl[CTRL_CURQ];
    for (int p = 0; p < 3; p++)
      if (ctrl[CTRL_CURQ] && meas.imag[p] > cur_lim) cur_ok = 1'b1; // [R3]
  end

  // hold machine, evaluated once per program cycle
  always_comb begin
    next_st = st;
    next_healthy_cnt = healthy_cnt;
    next_hold_cnt = hold_cnt;
    next_blk = blk;
    next_expired = expired;
    next_ang = ang;
    if (tick) begin
      next_blk = hold_block_in; // [R7]
      if (!ctrl[CTRL_EN] || hold_block_in) begin
        next_st = VHM_IDLE; // [R16]
        next_healthy_cnt = '0;
        next_expired = 1'b0;
        next_ang = meas.vang;
      end else begin
        case (st)
          VHM_IDLE, VHM_ARMED: begin
            next_ang = meas.vang; // live angles track [R5]
            if (all_healthy) begin
              if (healthy_cnt < 16'(HEALTHY_CYCLES))
                next_healthy_cnt = healthy_cnt + 16'h1;
              else
                next_st = VHM_ARMED; // [R1]
            end else if (st == VHM_ARMED && all_low) begin
              // stay armed, angles frozen, until the current qualifies
              next_ang = ang; // [R5]
              if (cur_ok) begin
                next_st = VHM_HOLD; // [R3]
                next_hold_cnt = '0;
              end
            end else begin
              next_st = VHM_IDLE;
              next_healthy_cnt = '0;
            end
          end
          VHM_HOLD: begin
            next_hold_cnt = hold_cnt + 16'h1;
            if (!all_low) begin
              next_st = VHM_IDLE; // recovery [R16]
              next_healthy_cnt = '0;
            end else if (32'(hold_cnt + 16'h1) * CYCLE_US / 1000
                         >= 32'(limit) * LIMIT_STEP_MS) begin
              next_st = VHM_SPENT; // [R14]
              next_expired = 1'b1;
            end
          end
          VHM_SPENT: begin
            if (all_healthy) begin
              next_st = VHM_IDLE;
              next_expired = 1'b0;
              next_healthy_cnt = '0;
            end
          end
          default: next_st = VHM_IDLE;
        endcase
      end
    end
  end

  // all registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_DEF;
      thr <= THR_DEF;
      cur_lim <= CUR_DEF;
      limit <= 16'(LIMIT_DEF_MS / LIMIT_STEP_MS);
      hsel_in <= '0;
      hsel_ord <= '0;
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_adr <= '0;
      div <= '0;
      st <= VHM_IDLE;
      healthy_cnt <= '0;
      hold_cnt <= '0;
      blk <= 1'b0;
      expired <= 1'b0;
      ang <= '0;
    end else begin
      ctrl <= next_ctrl;
      thr <= next_thr;
      cur_lim <= next_cur_lim;
      limit <= next_limit;
      hsel_in <= next_hsel_in;
      hsel_ord <= next_hsel_ord;
      ph_wr <= next_ph_wr;
      ph_rd <= next_ph_rd;
      ph_adr <= next_ph_adr;
      div <= next_div;
      st <= next_st;
      healthy_cnt <= next_healthy_cnt;
      hold_cnt <= next_hold_cnt;
      blk <= next_blk;
      expired <= next_expired;
      ang <= next_ang;
    end
  end

  // outputs to protection stages
  assign hold_active = (st == VHM_HOLD); // [R6]
  assign ref_amplitude = (st == VHM_HOLD) ? thr : meas.vmag[0]; // [R4]
  assign dependent_block = (st == VHM_SPENT); // [R14]
  assign clear_start_trip = (st == VHM_SPENT); // [R14]
  always_comb begin
    for (int i = 0; i < NUM_V; i++)
      ref_angle[i] = (ang[i] >= ANG_FULL) ? ang[i] - ANG_FULL : ang[i]; // [R8]
    ref_angle_valid = {v34_ok, v34_ok, 2'b11}; // [R9]
  end

  vhm_harm #(.ORDERS(NUM_H)) u_harm (
    .hclk(hclk),
    .hresetn(hresetn),
    .harm_in(harm_in),
    .sel_input(hsel_in),
    .sel_order(hsel_ord),
    .pct_mode(ctrl[CTRL_PCT]),
    .cycle_tick(tick),
    .harm_value(harm_value),
    .max_harmonic_value(max_harmonic_value),
    .thd_amp(thd_amp),
    .thd_pow(thd_pow)
  );

  // checks
  a_hold_output: assert property (@(posedge hclk) // [R4]
    disable iff (!hresetn) hold_active |-> ref_amplitude == thr)
    else $error("amplitude not threshold");
  a_angle_frozen: assert property (@(posedge hclk) // [R5]
    disable iff (!hresetn) $past(hold_active) && hold_active |-> $stable(ang))
    else $error("angle moved");
  a_enter_needs_low: assert property (@(posedge hclk) // [R2]
    disable iff (!hresetn) $rose(hold_active) |->
    $past(all_low && cur_ok && st == VHM_ARMED))
    else $error("bad entry");
  a_block_sampled: assert property (@(posedge hclk) // [R7]
    disable iff (!hresetn) !tick |=> $stable(blk))
    else $error("block moved mid cycle");
  a_spent_blocks: assert property (@(posedge hclk) // [R14]
    disable iff (!hresetn) $rose(dependent_block) |-> $past(hold_active))
    else $error("spent without hold");
  a_sync_valid: assert property (@(posedge hclk) // [R9]
    disable iff (!hresetn) ref_angle_valid[3] |-> ctrl[CTRL_SYNC])
    else $error("u4 valid");
  a_angle_range: assert property (@(posedge hclk) // [R8]
    disable iff (!hresetn) ref_angle[0] < ANG_FULL)
    else $error("angle range");
  a_disable_drop: assert property (@(posedge hclk) // [R16]
    disable iff (!hresetn) tick && !ctrl[CTRL_EN] |=> !hold_active)
    else $error("hold while off");
  a_arm_time: assert property (@(posedge hclk) // [R1]
    disable iff (!hresetn) $rose(st == VHM_ARMED) |->
    $past(healthy_cnt) == 16'(HEALTHY_CYCLES))
    else $error("early arm");
endmodule
`default_nettype wire

// ==== src/vhm_pkg.sv ====
// package: constants and carriers for the voltage hold block
package vhm_pkg;
  // clock and timing
  localparam int CLK_HZ = 40000000;
  localparam int CYCLE_US = 5000;            // program cycle period, us
  localparam int CYCLE_CLKS = CLK_HZ / 1000000 * CYCLE_US;
  localparam int HEALTHY_MS = 2500;          // healthy time before arming
  localparam int HEALTHY_CYCLES =
    (HEALTHY_MS * 1000 + CYCLE_US - 1) / CYCLE_US;
  localparam int LIMIT_MAX_MS = 50000;       // longest hold time setting
  localparam int LIMIT_DEF_MS = 15000;       // default hold time
  localparam int LIMIT_STEP_MS = 5;          // one count of the limit field
  // threshold in 0.01 % of nominal
  localparam logic [15:0] THR_DEF = 16'h05DC; // 15.00 %
  localparam logic [15:0] CUR_DEF = 16'h0064; // 1.00 x nominal
  localparam logic [15:0] ANG_FULL = 16'h8CA0; // 360.00 deg in 0.01 deg
  localparam int NUM_V = 4;                  // voltage inputs
  localparam int NUM_H = 31;                 // harmonic orders 1..31
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THR = 8'h04;
  localparam logic [7:0] OFS_CUR = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_HSEL = 8'h14;
  localparam logic [7:0] OFS_HARM = 8'h18;
  localparam logic [7:0] OFS_MAXH = 8'h1C;
  localparam logic [7:0] OFS_THDA = 8'h20;
  localparam logic [7:0] OFS_THDP = 8'h24;
  localparam logic [7:0] OFS_ANG0 = 8'h40;   // four angles, one per word
  // control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_CURQ = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_PCT = 3;
  localparam logic [3:0] CTRL_DEF = 4'h1;
  // status fields
  localparam int ST_ACT = 0;
  localparam int ST_ARM = 1;
  localparam int ST_EXP = 2;
  localparam int ST_BLK = 3;
  localparam int ST_V34 = 4;
  // measurement carrier
  typedef struct packed {
    logic [NUM_V-1:0][15:0] vmag;   // magnitudes, 0.01 % nominal
    logic [NUM_V-1:0] vused;        // input in use
    logic [NUM_V-1:0][15:0] vang;   // angles, 0.01 deg
    logic [2:0][15:0] imag;         // phase currents, 0.01 x nominal
  } vhm_meas_t;
  // harmonic sample carrier, one order of one input
  typedef struct packed {
    logic valid;
    logic [1:0] input_sel;
    logic [4:0] order;              // 0 fundamental .. 30 thirty-first
    logic [23:0] value;             // absolute, 0.001 V
  } vhm_harm_t;
  typedef enum logic [1:0] {
    VHM_IDLE, VHM_ARMED, VHM_HOLD, VHM_SPENT
  } vhm_state_t;
endpackage

// ==== src/vhm_harm.sv ====
// harmonic store, scale, maximum and distortion for one selected input
`timescale 1ns/10ps
`default_nettype none
module vhm_harm
  import vhm_pkg::*;
#(
  parameter int ORDERS = NUM_H
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // samples and selection
  input wire vhm_harm_t harm_in,
  input wire logic [1:0] sel_input,
  input wire logic [4:0] sel_order,
  input wire logic pct_mode,
  input wire logic cycle_tick,
  // results
  output logic [23:0] harm_value,
  output logic [23:0] max_harmonic_value,
  output logic [23:0] thd_amp,
  output logic [23:0] thd_pow
);
  initial begin
    // order field is five bits, so 32 orders would wrap the range test
    if (ORDERS < 2 || ORDERS > 31) $error("vhm_harm: bad order count");
  end
  // one word per input per order
  logic [23:0] mem [NUM_V*ORDERS];
  logic [23:0] next_harm_value, next_max, next_thd_amp, next_thd_pow;
  logic [23:0] fund;
  logic [47:0] sum, sq_sum, scaled;
  logic [23:0] h;
  always_ff @(posedge hclk) begin
    if (harm_in.valid && harm_in.order < 5'(ORDERS))
      mem[32'(harm_in.input_sel) * ORDERS + 32'(harm_in.order)]
        <= harm_in.value;
  end
  // per cycle recompute for the selected input; sums are coarse estimates
  always_comb begin
    fund = mem[32'(sel_input) * ORDERS];
    next_max = '0;
    sum = '0;
    sq_sum = '0;
    for (int k = 1; k < ORDERS; k++) begin
      h = mem[32'(sel_input) * ORDERS + k];
      if (h > next_max) next_max = h; // [R12]
      sum = sum + 48'(h);
      sq_sum = sq_sum + 48'(h) * 48'(h) / 48'h400;
    end
    scaled = 48'(mem[32'(sel_input) * ORDERS + 32'(sel_order)]);
    // percent mode: 0.001 % of fundamental [R11]
    if (pct_mode && fund != 0) begin
      next_harm_value = 24'(scaled * 48'h186A0 / 48'(fund));
      next_max = 24'(48'(next_max) * 48'h186A0 / 48'(fund));
    end else begin
      next_harm_value = scaled[23:0]; // [R10]
    end
    next_thd_amp = (fund != 0) ? 24'(sum * 48'h186A0 / 48'(fund))
                   : '0; // [R13]
    next_thd_pow = (fund != 0) ? 24'(sq_sum * 48'h400 * 48'h186A0
                   / (48'(fund) * 48'(fund))) : '0; // [R13]
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      harm_value <= '0;
      max_harmonic_value <= '0;
      thd_amp <= '0;
      thd_pow <= '0;
    end else if (cycle_tick) begin
      harm_value <= next_harm_value;
      max_harmonic_value <= next_max;
      thd_amp <= next_thd_amp;
      thd_pow <= next_thd_pow;
    end
  end
endmodule
`default_nettype wire

// ==== tb/vhm_front.sv ====
// measurement front end model feeding the voltage hold block
`timescale 1ns/10ps
`default_nettype none
module vhm_front
  import vhm_pkg::*;
(
  // clock
  input wire logic hclk,
  // scenario controls
  input wire logic [3:0] low_mask,
  input wire logic cur_high,
  input wire logic fault_ang,
  // to the block
  output var vhm_meas_t meas,
  output var vhm_harm_t harm_in
);
  // healthy 100 %, collapsed 1 % which is near zero but not exactly zero
  always_comb begin
    meas.vused = 4'hF;
    for (int i = 0; i < NUM_V; i++) begin
      meas.vmag[i] = low_mask[i] ? 16'h0064 : 16'h2710;
      // angles jump at the fault so a held value is told from a live one
      meas.vang[i] = fault_ang ? 16'(1000 + i * 1000) : 16'(32999 + i * 1000);
    end
    // only phase one rises, so one phase alone must satisfy the qualifier
    for (int i = 0; i < 3; i++) begin
      meas.imag[i] = (cur_high && i == 0) ? 16'h00C8 : 16'h0032;
    end
  end
  // no sample pending at start
  initial harm_in = '0;
  // one harmonic sample, valid for exactly one cycle
  task automatic send_harm(input logic [4:0] ord, input logic [23:0] val);
    @(posedge hclk);
    harm_in <= '{1'b1, 2'h0, ord, val};
    @(posedge hclk);
    harm_in.valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the voltage hold block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import vhm_pkg::*;
  localparam int CYC = 20; // short program cycle keeps arming time small
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hold_block_in, cur_high, fault_ang;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] low_mask;
  logic hreadyout, hresp, hold_active, dependent_block, clear_start_trip;
  logic [15:0] ref_amplitude;
  logic [NUM_V-1:0][15:0] ref_angle;
  logic [NUM_V-1:0] ref_angle_valid;
  vhm_meas_t meas;
  vhm_harm_t harm_in;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // 40 MHz clock
  always #12.5 hclk = ~hclk;
  // device under test, hready fed back from the only slave
  vhm_top #(.CYCLE_LEN(CYC)) vhm_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .meas(meas), .harm_in(harm_in),
    .hold_block_in(hold_block_in), .hold_active(hold_active),
    .ref_amplitude(ref_amplitude), .ref_angle(ref_angle),
    .ref_angle_valid(ref_angle_valid), .dependent_block(dependent_block),
    .clear_start_trip(clear_start_trip));
  // far side model
  vhm_front vhm_front_inst (
    .hclk(hclk), .low_mask(low_mask), .cur_high(cur_high),
    .fault_ang(fault_ang), .meas(meas), .harm_in(harm_in));
  // verdict and end of run
  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, well above the roughly 45k cycles the run needs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      finish_test();
    end
  end
  // compare and report
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // one single word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(n, e, x);
    // slave must always answer OKAY
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic ticks(input int n);
    repeat (n * CYC) @(posedge hclk);
  endtask
  // healthy voltages a few ticks past the arming time
  task automatic arm();
    @(posedge hclk);
    low_mask <= 4'h0;
    cur_high <= 1'b0;
    fault_ang <= 1'b0;
    ticks(505);
  endtask
  // collapse the masked inputs and let three ticks pass
  task automatic drop(input logic [3:0] m);
    @(posedge hclk);
    low_mask <= m;
    fault_ang <= 1'b1;
    ticks(3);
  endtask
  task automatic t_regs();
    rd_chk("thr", OFS_THR, 32'h000005DC);
    rd_chk("cur", OFS_CUR, 32'h00000064);
    rd_chk("limit", OFS_LIMIT, 32'h00000BB8);
    wr_reg(8'h30, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h30, 32'h00000000);
  endtask
  // collapse before the healthy time has run out
  task automatic t_early();
    ticks(100);
    drop(4'hF);
    chk("hold early", 32'h0, 32'(hold_active));
  endtask
  // one used input low is not enough
  task automatic t_partial();
    arm();
    rd_chk("armed", OFS_STAT, 32'h00000002);
    drop(4'h1);
    chk("hold partial", 32'h0, 32'(hold_active));
  endtask
  task automatic t_hold();
    arm();
    drop(4'hF);
    chk("hold", 32'h1, 32'(hold_active));
    chk("amplitude", 32'(THR_DEF), 32'(ref_amplitude));
    for (int i = 0; i < NUM_V; i++) begin
      chk("held angle", 32'(32999 + i * 1000), 32'(ref_angle[i]));
    end
    hold_block_in <= 1'b1;
    ticks(2);
    chk("hold blocked", 32'h0, 32'(hold_active));
    hold_block_in <= 1'b0;
    low_mask <= 4'h0;
    ticks(3);
    chk("live angle", 32'h000003E8, 32'(ref_angle[0]));
  endtask
  task automatic t_curq();
    wr_reg(OFS_CTRL, 32'h00000003);
    arm();
    drop(4'hF);
    chk("hold no current", 32'h0, 32'(hold_active));
    cur_high <= 1'b1;
    ticks(3);
    chk("hold current", 32'h1, 32'(hold_active));
    wr_reg(OFS_CTRL, 32'h00000002);
    ticks(3);
    chk("hold disabled", 32'h0, 32'(hold_active));
    wr_reg(OFS_CTRL, 32'h00000001);
  endtask
  // limit of ten counts of 5 ms, ten program cycles here
  task automatic t_limit();
    wr_reg(OFS_LIMIT, 32'h0000000A);
    arm();
    drop(4'hF);
    chk("hold before limit", 32'h1, 32'(hold_active));
    ticks(10);
    chk("hold after limit", 32'h0, 32'(hold_active));
    chk("dep block", 32'h1, 32'(dependent_block));
    chk("clear trips", 32'h1, 32'(clear_start_trip));
    rd_chk("expired", OFS_STAT, 32'h00000004);
    low_mask <= 4'h0;
    ticks(3);
    chk("dep block off", 32'h0, 32'(dependent_block));
  endtask
  task automatic t_sync();
    wr_reg(OFS_CTRL, 32'h00000005);
    ticks(1);
    chk("valid sync", 32'h0000000F, 32'(ref_angle_valid));
    rd_chk("stat sync", OFS_STAT, 32'h00000010);
    wr_reg(OFS_CTRL, 32'h00000001);
    ticks(1);
    chk("valid plain", 32'h00000003, 32'(ref_angle_valid));
  endtask
  // live angles up to 359.99 degrees read back in 0.01 degree steps
  task automatic t_ang();
    fault_ang <= 1'b0;
    ticks(1);
    for (int i = 0; i < NUM_V; i++) begin
      rd_chk("angle", OFS_ANG0 + 8'(4 * i), 32'(32999 + i * 1000));
    end
  endtask
  function automatic logic [23:0] hv(input int k);
    return (k == 0) ? 24'h0003E8 : (k == 6) ? 24'h001388 : 24'h000064;
  endfunction
  task automatic t_harm();
    for (int k = 0; k < NUM_H; k++) begin
      vhm_front_inst.send_harm(5'(k), hv(k));
    end
    ticks(1);
    for (int k = 0; k < NUM_H; k++) begin
      wr_reg(OFS_HSEL, {19'h0, 5'(k), 8'h00});
      // results refresh only on the program cycle tick
      ticks(1);
      rd_chk("harmonic", OFS_HARM, 32'(hv(k)));
    end
    rd_chk("max harmonic", OFS_MAXH, 32'h00001388);
    // 100 over 1000 is 10 %, 10000 in 0.001 % steps
    wr_reg(OFS_CTRL, 32'h00000009);
    wr_reg(OFS_HSEL, 32'h00000100);
    ticks(1);
    rd_chk("percent", OFS_HARM, 32'h00002710);
    wr_reg(OFS_CTRL, 32'h00000001);
  endtask
  // main sequence
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    hold_block_in = 1'b0;
    low_mask = 4'h0;
    cur_high = 1'b0;
    fault_ang = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_early();
    t_partial();
    t_hold();
    t_curq();
    t_limit();
    t_sync();
    t_ang();
    t_harm();
    finish_test();
  end
endmodule
`default_nettype wire
